// ==== rtl/stp_consts.svh ====
/*
 * Offsets, field positions, reset values, pattern words and seeds of the
 * serial link test pattern generator. Assumes it is included once per
 * compilation unit by any file that needs the register map.
 */
// Function
// - patterns inserted at selectable path points
// - writing 0x81 to address zero resets
// - bits 3:0 choose pattern, zero is off
// - checkerboard and word toggle alternate per step
// - five PN sequences with fixed seeds
// - ramp wraps at insertion point width
// - user repeat cycles four patterns forever
// - user single plays four patterns, then zeros
// - user patterns from eight byte registers
// - bits 5:4 choose point, 00 samples
// - every sample same word, one per frame
// - ten-bit point uses upper ten bits of user words
// - link control bit 5 enables sample test
// - sample test sends raw converter samples
// - point 01 is ten-bit physical input
// - point 10 is octet scrambler input
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH

`define STP_ADDR_W 15
`define STP_ADDR_CONFIG 15'h0000
`define STP_ADDR_USER_FIRST 15'h0551
`define STP_ADDR_USER_LAST 15'h0558
`define STP_ADDR_LINK_CTRL 15'h0571
`define STP_ADDR_TEST_CTRL 15'h0573
`define STP_ADDR_LINK_TEST 15'h0574
`define STP_ADDR_STATUS 15'h057F

`define STP_REG_RESET 8'h00
`define STP_SOFT_RESET_VAL 8'h81
`define STP_CONFIG_KEEP_MASK 8'h7E
`define STP_SAMPLE_TEST_BIT 5
`define STP_MODE_MSB 3
`define STP_POINT_MSB 5
`define STP_POINT_LSB 4

`define STP_MODE_OFF 4'h0
`define STP_MODE_CHECKER 4'h1
`define STP_MODE_TOGGLE 4'h2
`define STP_MODE_PN31 4'h3
`define STP_MODE_TWENTYTHREE_BIT_PRBS 4'h4
`define STP_MODE_PN15 4'h5
`define STP_MODE_PN9 4'h6
`define STP_MODE_PN7 4'h7
`define STP_MODE_RAMP 4'h8
`define STP_MODE_USER_REPEAT 4'hE
`define STP_MODE_USER_SINGLE 4'hF

`define STP_POINT_SAMPLE 2'h0
`define STP_POINT_PHY10 2'h1
`define STP_POINT_SCRAMBLER8 2'h2

`define STP_SEED_PN31 31'h0003AFFF
`define STP_SEED_TWENTYTHREE_BIT_PRBS 31'h003AFF
`define STP_SEED_PN15 31'h03AF
`define STP_SEED_PN9 31'h092
`define STP_SEED_PN7 31'h07
`define STP_LEN_PN31 5'h1F
`define STP_TAP_PN31 5'h1C
`define STP_LEN_TWENTYTHREE_BIT_PRBS 5'h17
`define STP_TAP_TWENTYTHREE_BIT_PRBS 5'h12
`define STP_LEN_PN15 5'h0F
`define STP_TAP_PN15 5'h0E
`define STP_LEN_PN9 5'h09
`define STP_TAP_PN9 5'h05
`define STP_LEN_PN7 5'h07
`define STP_TAP_PN7 5'h06

`define STP_CHECKER_EVEN 16'h5555
`define STP_CHECKER_ODD 16'hAAAA
`define STP_WIDTH_SAMPLE 5'h10
`define STP_WIDTH_PHY10 5'h0A
`define STP_WIDTH_SCRAMBLER8 5'h08
`define STP_USER_SHIFT_SAMPLE 4'h0
`define STP_USER_SHIFT_PHY10 4'h6
`define STP_USER_SHIFT_SCRAMBLER8 4'h9
`define STP_USER_COUNT 4

`endif

// ==== rtl/stp_fifo.sv ====
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; clr empties it like a reset.
 */
module stp_fifo #(
    parameter int WIDTH = 67,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clr,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic push;
    logic pop;

    assign push = s_valid && s_ready;
    assign pop = m_valid && m_ready;
    assign m_data = mem_q[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + (AW+1)'(1);
        end else if (pop && !push) begin
            count_d = count_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q] <= s_data;
        end
    end

    // ready and valid are registered so no output depends on the far side
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            s_ready <= 1'b0;
            m_valid <= 1'b0;
        end else if (clr) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            s_ready <= 1'b0;
            m_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + AW'(1);
            end
            count_q <= count_d;
            s_ready <= (count_d < (AW+1)'(DEPTH));
            m_valid <= (count_d != '0);
        end
    end
endmodule : stp_fifo

// ==== rtl/stp_pattern_gen.sv ====
/*
 * Test pattern generator of the serial output path: register port,
 * pattern sources, insertion point formatting, frame FIFO and output stage.
 * Assumes a register port already decoded from the serial control logic on
 * clk_sys, and a converter frame stream and a lane-side consumer on clk_sys.
 */
`include "stp_consts.svh"

module stp_pattern_gen #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [`STP_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic adc_valid,
    output logic adc_ready,
    input wire logic [63:0] adc_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [63:0] out_data,
    output logic [1:0] out_point,
    output logic out_is_pattern
);
    localparam int FW = 67;

    logic soft_rst_q;
    logic [7:0] config_q;
    logic [7:0] link_ctrl_q;
    logic [7:0] test_ctrl_q;
    logic [7:0] link_test_q;
    logic [7:0] user_byte_q [2*`STP_USER_COUNT];
    logic test_seen_q;

    logic [30:0] pn_q;
    logic [30:0] pn_d;
    logic [15:0] pn_word;
    logic [15:0] ramp_q;
    logic phase_q;
    logic [1:0] user_idx_q;
    stp_pkg::stp_user_state_t user_state_q;

    logic wr_config;
    logic wr_test;
    logic [3:0] mode;
    logic [1:0] point;
    stp_pkg::stp_kind_t kind;
    logic [4:0] pn_len;
    logic [4:0] pn_tap;
    logic [4:0] width;
    logic [3:0] user_shift;
    logic [15:0] width_mask;
    logic [15:0] user_word;
    logic [15:0] pat_word;
    logic [63:0] frame_word;
    logic is_pattern;
    logic advance;
    logic [FW-1:0] fifo_out;
    logic fifo_valid;
    logic fifo_pop;

    assign wr_config = reg_wr && (reg_addr == `STP_ADDR_CONFIG);
    assign wr_test = reg_wr && (reg_addr == `STP_ADDR_TEST_CTRL);
    assign mode = test_ctrl_q[`STP_MODE_MSB:0];
    assign point = test_ctrl_q[`STP_POINT_MSB:`STP_POINT_LSB];

    // self-clearing reset pulse, one cycle after the write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= wr_config && (reg_wdata == `STP_SOFT_RESET_VAL);
        end
    end

    // register file; the reset bits of config are never stored
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            config_q <= `STP_REG_RESET;
            link_ctrl_q <= `STP_REG_RESET;
            test_ctrl_q <= `STP_REG_RESET;
            link_test_q <= `STP_REG_RESET;
            for (int i = 0; i < 2*`STP_USER_COUNT; i++) begin
                user_byte_q[i] <= `STP_REG_RESET;
            end
        end else if (soft_rst_q) begin
            config_q <= `STP_REG_RESET;
            link_ctrl_q <= `STP_REG_RESET;
            test_ctrl_q <= `STP_REG_RESET;
            link_test_q <= `STP_REG_RESET;
            for (int i = 0; i < 2*`STP_USER_COUNT; i++) begin
                user_byte_q[i] <= `STP_REG_RESET;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                `STP_ADDR_CONFIG: config_q <= reg_wdata & `STP_CONFIG_KEEP_MASK;
                `STP_ADDR_LINK_CTRL: link_ctrl_q <= reg_wdata;
                `STP_ADDR_TEST_CTRL: test_ctrl_q <= reg_wdata;
                `STP_ADDR_LINK_TEST: link_test_q <= reg_wdata;
                default: begin
                    if (reg_addr >= `STP_ADDR_USER_FIRST && reg_addr <= `STP_ADDR_USER_LAST) begin
                        user_byte_q[3'(reg_addr - `STP_ADDR_USER_FIRST)] <= reg_wdata;
                    end
                end
            endcase
        end
    end

    // read port: one cycle latency, unmapped addresses read zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `STP_ADDR_CONFIG: reg_rdata <= config_q;
                    `STP_ADDR_LINK_CTRL: reg_rdata <= link_ctrl_q;
                    `STP_ADDR_TEST_CTRL: reg_rdata <= test_ctrl_q;
                    `STP_ADDR_LINK_TEST: reg_rdata <= link_test_q;
                    `STP_ADDR_STATUS: reg_rdata <= {3'h0, test_seen_q, user_state_q == stp_pkg::STP_USER_DONE, user_idx_q, is_pattern};
                    default: begin
                        if (reg_addr >= `STP_ADDR_USER_FIRST && reg_addr <= `STP_ADDR_USER_LAST) begin
                            reg_rdata <= user_byte_q[3'(reg_addr - `STP_ADDR_USER_FIRST)];
                        end else begin
                            reg_rdata <= 8'h00;
                        end
                    end
                endcase
            end
        end
    end

    // leaving a test mode without soft reset keeps the lanes on zero words
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            test_seen_q <= 1'b0;
        end else if (soft_rst_q) begin
            test_seen_q <= 1'b0;
        end else if (kind != stp_pkg::STP_KIND_OFF) begin
            test_seen_q <= 1'b1;
        end
    end

    always_comb begin
        case (mode)
            `STP_MODE_CHECKER: kind = stp_pkg::STP_KIND_CHECKER;
            `STP_MODE_TOGGLE: kind = stp_pkg::STP_KIND_TOGGLE;
            `STP_MODE_PN31, `STP_MODE_TWENTYTHREE_BIT_PRBS, `STP_MODE_PN15,
            `STP_MODE_PN9, `STP_MODE_PN7: kind = stp_pkg::STP_KIND_PN;
            `STP_MODE_RAMP: kind = stp_pkg::STP_KIND_RAMP;
            `STP_MODE_USER_REPEAT: kind = stp_pkg::STP_KIND_USER_REPEAT;
            `STP_MODE_USER_SINGLE: kind = stp_pkg::STP_KIND_USER_SINGLE;
            default: kind = stp_pkg::STP_KIND_OFF;
        endcase
    end

    // polynomial per mode; tap for x^L + x^T + 1
    always_comb begin
        case (mode)
            `STP_MODE_PN31: begin
                pn_len = `STP_LEN_PN31;
                pn_tap = `STP_TAP_PN31;
            end
            `STP_MODE_TWENTYTHREE_BIT_PRBS: begin
                pn_len = `STP_LEN_TWENTYTHREE_BIT_PRBS;
                pn_tap = `STP_TAP_TWENTYTHREE_BIT_PRBS;
            end
            `STP_MODE_PN15: begin
                pn_len = `STP_LEN_PN15;
                pn_tap = `STP_TAP_PN15;
            end
            `STP_MODE_PN9: begin
                pn_len = `STP_LEN_PN9;
                pn_tap = `STP_TAP_PN9;
            end
            default: begin
                pn_len = `STP_LEN_PN7;
                pn_tap = `STP_TAP_PN7;
            end
        endcase
    end

    // word width at each insertion point; 'b11 is served like the sample input
    always_comb begin
        case (point)
            `STP_POINT_PHY10: begin
                width = `STP_WIDTH_PHY10;
                user_shift = `STP_USER_SHIFT_PHY10;
            end
            `STP_POINT_SCRAMBLER8: begin
                width = `STP_WIDTH_SCRAMBLER8;
                user_shift = `STP_USER_SHIFT_SCRAMBLER8;
            end
            default: begin
                width = `STP_WIDTH_SAMPLE;
                user_shift = `STP_USER_SHIFT_SAMPLE;
            end
        endcase
        width_mask = 16'((17'h1 << width) - 17'h1);
    end

    function automatic logic [30:0] seed_of(input logic [3:0] m);
        case (m)
            `STP_MODE_PN31: seed_of = `STP_SEED_PN31;
            `STP_MODE_TWENTYTHREE_BIT_PRBS: seed_of = `STP_SEED_TWENTYTHREE_BIT_PRBS;
            `STP_MODE_PN15: seed_of = `STP_SEED_PN15;
            `STP_MODE_PN9: seed_of = `STP_SEED_PN9;
            `STP_MODE_PN7: seed_of = `STP_SEED_PN7;
            default: seed_of = 31'h0;
        endcase
    endfunction : seed_of

    // serial LFSR stepped once per bit of the current word, msb out first
    always_comb begin
        logic [30:0] s;
        logic fb;
        s = pn_q;
        fb = 1'b0;
        pn_word = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (5'(i) < width) begin
                pn_word = {pn_word[14:0], s[pn_len - 5'h1]};
                fb = s[pn_len - 5'h1] ^ s[pn_tap - 5'h1];
                s = {s[29:0], fb} & 31'((32'h1 << pn_len) - 32'h1);
            end
        end
        pn_d = s;
    end

    assign user_word = {user_byte_q[{user_idx_q, 1'b1}], user_byte_q[{user_idx_q, 1'b0}]};

    always_comb begin
        case (kind)
            stp_pkg::STP_KIND_CHECKER:
                pat_word = phase_q ? `STP_CHECKER_ODD : `STP_CHECKER_EVEN;
            stp_pkg::STP_KIND_TOGGLE: pat_word = phase_q ? 16'hFFFF : 16'h0000;
            stp_pkg::STP_KIND_PN: pat_word = pn_word;
            stp_pkg::STP_KIND_RAMP: pat_word = ramp_q;
            stp_pkg::STP_KIND_USER_REPEAT: pat_word = user_word >> user_shift;
            stp_pkg::STP_KIND_USER_SINGLE: begin
                if (user_state_q == stp_pkg::STP_USER_DONE) begin
                    pat_word = 16'h0000;
                end else begin
                    pat_word = user_word >> user_shift;
                end
            end
            default: pat_word = 16'h0000;
        endcase
        pat_word = pat_word & width_mask;
    end

    // pattern replaces samples unless off; sample test passes raw data
    assign is_pattern = (kind != stp_pkg::STP_KIND_OFF) && !link_ctrl_q[`STP_SAMPLE_TEST_BIT];

    always_comb begin
        if (link_ctrl_q[`STP_SAMPLE_TEST_BIT]) begin
            frame_word = adc_data;
        end else if (is_pattern) begin
            if (point == `STP_POINT_PHY10 || point == `STP_POINT_SCRAMBLER8) begin
                frame_word = {48'h0, pat_word};
            end else begin
                frame_word = {4{pat_word}};
            end
        end else if (test_seen_q) begin
            frame_word = 64'h0;
        end else begin
            frame_word = adc_data;
        end
    end

    // one pattern step per frame accepted into the FIFO
    assign advance = adc_valid && adc_ready;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pn_q <= 31'h0;
            ramp_q <= 16'h0000;
            phase_q <= 1'b0;
        end else if (soft_rst_q) begin
            pn_q <= 31'h0;
            ramp_q <= 16'h0000;
            phase_q <= 1'b0;
        end else if (wr_test) begin
            pn_q <= seed_of(reg_wdata[`STP_MODE_MSB:0]);
            ramp_q <= 16'h0000;
            phase_q <= 1'b0;
        end else if (advance && is_pattern) begin
            pn_q <= pn_d;
            ramp_q <= ramp_q + 16'h0001;
            phase_q <= !phase_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            user_idx_q <= 2'h0;
            user_state_q <= stp_pkg::STP_USER_PLAYING;
        end else if (soft_rst_q || wr_test) begin
            user_idx_q <= 2'h0;
            user_state_q <= stp_pkg::STP_USER_PLAYING;
        end else if (advance && is_pattern) begin
            user_idx_q <= user_idx_q + 2'h1;
            case (user_state_q)
                stp_pkg::STP_USER_PLAYING: begin
                    if (kind == stp_pkg::STP_KIND_USER_SINGLE && user_idx_q == 2'h3) begin
                        user_state_q <= stp_pkg::STP_USER_DONE;
                    end
                end
                stp_pkg::STP_USER_DONE: user_state_q <= stp_pkg::STP_USER_DONE;
                default: user_state_q <= stp_pkg::STP_USER_PLAYING;
            endcase
        end
    end

    // FIFO decouples the frame source from lane back-pressure
    stp_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .clr(soft_rst_q),
        .s_valid(adc_valid),
        .s_ready(adc_ready),
        .s_data({is_pattern, point, frame_word}),
        .m_valid(fifo_valid),
        .m_ready(fifo_pop),
        .m_data(fifo_out)
    );

    assign fifo_pop = !out_valid || out_ready;

    // registered output stage so every lane-side output is a flop
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= 64'h0;
            out_point <= 2'h0;
            out_is_pattern <= 1'b0;
        end else if (soft_rst_q) begin
            out_valid <= 1'b0;
        end else if (fifo_pop) begin
            out_valid <= fifo_valid;
            if (fifo_valid) begin
                out_data <= fifo_out[63:0];
                out_point <= fifo_out[65:64];
                out_is_pattern <= fifo_out[66];
            end
        end
    end
endmodule : stp_pattern_gen

// ==== rtl/stp_pkg.sv ====
/*
 * Types shared by the test pattern generator files.
 * Assumes stp_consts.svh supplies all numeric constants.
 */
package stp_pkg;
    typedef enum logic [2:0] {
        STP_KIND_OFF,
        STP_KIND_CHECKER,
        STP_KIND_TOGGLE,
        STP_KIND_PN,
        STP_KIND_RAMP,
        STP_KIND_USER_REPEAT,
        STP_KIND_USER_SINGLE
    } stp_kind_t;

    typedef enum logic {
        STP_USER_PLAYING,
        STP_USER_DONE
    } stp_user_state_t;
endpackage : stp_pkg

// ==== sim/stp_lane_model.sv ====
/*
 * Lane-side consumer model: drives out_ready and queues each word taken.
 * Assumes the bench sets stall and slow; entries are {pattern, point, data}.
 */
module stp_lane_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic stall,
    input wire logic slow,
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [63:0] out_data,
    input wire logic [1:0] out_point,
    input wire logic out_is_pattern
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [66:0] words[$];
    logic phase_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end
    // slow mode takes every other cycle to exercise the hold path
    assign out_ready = !stall && !(slow && phase_q);
    always @(posedge clk_sys) begin
        if (!rst && out_valid && out_ready) begin
            words.push_back({out_is_pattern, out_point, out_data});
        end
    end
endmodule : stp_lane_model

// ==== sim/stp_pattern_gen_properties.sv ====
/*
 * Concurrent checks on the ports of the test pattern generator.
 * Assumes it is bound to stp_pattern_gen and sees only its ports.
 */
module stp_pattern_gen_checker #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [14:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [63:0] out_data,
    input wire logic [1:0] out_point,
    input wire logic out_is_pattern
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sr_write;
    assign sr_write = reg_wr && reg_addr == 15'h0000 && reg_wdata == 8'h81;
    // soft reset drops held words, so the hold check skips that window
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_RVALID_PULSE: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    AST_RVALID_CAUSE: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read answer without request");
    AST_OUT_HOLD: assert property (out_valid && !out_ready && !sr_write
        && !$past(sr_write) |=> out_valid && $stable(out_data) && $stable(out_point)
        && $stable(out_is_pattern))
        else $error("lane word changed while stalled");
    AST_SOFT_CLEARS: assert property (sr_write |-> ##2 !out_valid)
        else $error("soft reset left a lane word");
    AST_CONFIG_SELF_CLEAR: assert property (reg_rd && reg_addr == 15'h0000 |=>
        !reg_rdata[7] && !reg_rdata[0])
        else $error("reset bits did not clear");
    AST_SAMPLE_REPEAT: assert property (out_valid && out_is_pattern && out_point == 2'h0 |->
        out_data[63:48] == out_data[15:0] && out_data[47:32] == out_data[15:0]
        && out_data[31:16] == out_data[15:0])
        else $error("samples of a frame differ");
    AST_PHY10_WIDTH: assert property (out_valid && out_is_pattern && out_point == 2'h1 |->
        out_data[63:10] == 54'h0)
        else $error("symbol wider than ten bits");
    AST_OCTET_WIDTH: assert property (out_valid && out_is_pattern && out_point == 2'h2 |->
        out_data[63:8] == 56'h0)
        else $error("octet wider than eight bits");
    COV_READ: cover property (reg_rvalid);
    COV_PHY10: cover property (out_valid && out_is_pattern && out_point == 2'h1);
    COV_SOFT: cover property (sr_write);
endmodule : stp_pattern_gen_checker

// ==== sim/tb_top.sv ====
/*
 * Self-checking bench of the test pattern generator.
 * Assumes the lane model and the checker are compiled before it.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [14:0] reg_addr = 15'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic adc_valid = 1'b0;
    logic [63:0] adc_data = 64'h0;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid, adc_ready, out_valid, out_ready, out_is_pattern;
    logic [63:0] out_data;
    logic [1:0] out_point;
    int bad_count = 0;
    int cmp_count = 0;
    logic [15:0] up [4] = '{16'h8001, 16'h4C3F, 16'hF0A5, 16'h1E96};
    localparam logic [66:0] ALL = {67{1'b1}};

    stp_pattern_gen #(.FIFO_DEPTH(4)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_valid(adc_valid),
        .adc_ready(adc_ready), .adc_data(adc_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .out_point(out_point),
        .out_is_pattern(out_is_pattern));
    stp_lane_model i_lane (.clk_sys(clk_sys), .rst(rst), .stall(stall), .slow(slow),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .out_point(out_point), .out_is_pattern(out_is_pattern));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [66:0] got, input logic [66:0] exp, input logic [66:0] m);
        cmp_count++;
        if ((got & m) !== (exp & m)) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [14:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk({58'h0, reg_rvalid, reg_rdata}, {58'h0, 1'b1, exp}, ALL);
    endtask : rd

    task automatic send(input int n, input logic [63:0] base);
        int t;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            adc_valid = 1'b1;
            adc_data = base + 64'(i);
            t = 0;
            while (!adc_ready && t < 200) begin
                @(negedge clk_sys);
                t++;
            end
        end
        @(negedge clk_sys);
        adc_valid = 1'b0;
    endtask : send

    task automatic take(input logic [66:0] exp, input logic [66:0] m);
        int t;
        t = 0;
        while (i_lane.words.size() == 0 && t < 2000) begin
            @(negedge clk_sys);
            t++;
        end
        chk(i_lane.words.size() > 0 ? i_lane.words.pop_front() : '0, exp, m);
    endtask : take

    task automatic t_regs_raw();
        rd(15'h0573, 8'h00);
        wr(15'h0574, 8'h05);
        rd(15'h0574, 8'h05);
        rd(15'h0600, 8'h00);
        send(2, 64'h1111_2222_3333_4440);
        for (int i = 0; i < 2; i++) take({3'b000, 64'h1111_2222_3333_4440 + 64'(i)}, ALL);
    endtask : t_regs_raw

    task automatic t_words();
        wr(15'h0573, 8'h11);
        send(5, 64'h0);
        for (int i = 0; i < 5; i++) take({3'b101, 54'h0, i[0] ? 10'h2AA : 10'h155}, ALL);
        wr(15'h0573, 8'h02);
        send(4, 64'h0);
        for (int i = 0; i < 4; i++) take({3'b100, {4{i[0] ? 16'hFFFF : 16'h0000}}}, ALL);
        slow = 1'b1;
        wr(15'h0573, 8'h28);
        send(260, 64'h0);
        for (int i = 0; i < 260; i++) take({3'b110, 56'h0, 8'(i)}, ALL);
        slow = 1'b0;
    endtask : t_words

    task automatic t_prbs();
        logic [8:0] s;
        logic [15:0] w;
        s = 9'h092;
        wr(15'h0573, 8'h06);
        send(4, 64'h0);
        for (int i = 0; i < 4; i++) begin
            for (int b = 0; b < 16; b++) begin
                w = {w[14:0], s[8]};
                s = {s[7:0], s[8] ^ s[4]};
            end
            take({3'b100, {4{w}}}, ALL);
        end
        wr(15'h0573, 8'h06);
        send(1, 64'h0);
        take({3'b100, {4{16'h496F}}}, ALL);
    endtask : t_prbs

    task automatic t_user();
        for (int k = 0; k < 4; k++) begin
            wr(15'h0551 + 15'(2 * k), up[k][7:0]);
            wr(15'h0552 + 15'(2 * k), up[k][15:8]);
        end
        wr(15'h0573, 8'h0E);
        send(6, 64'h0);
        for (int i = 0; i < 6; i++) take({3'b100, {4{up[i % 4]}}}, ALL);
        wr(15'h0573, 8'h1F);
        send(6, 64'h0);
        for (int i = 0; i < 6; i++) take({3'b101, 54'h0, i < 4 ? up[i][15:6] : 10'h0}, ALL);
        rd(15'h057F, 8'h1D);
    endtask : t_user

    task automatic t_leave();
        wr(15'h0573, 8'h00);
        send(1, 64'h7777);
        take(67'h0, ALL);
        wr(15'h0000, 8'h81);
        rd(15'h0000, 8'h00);
        rd(15'h0573, 8'h00);
        rd(15'h0551, 8'h00);
        wr(15'h0573, 8'h09);
        send(1, 64'h9999);
        take({3'b000, 64'h9999}, ALL);
    endtask : t_leave

    task automatic t_sample();
        wr(15'h0571, 8'h20);
        wr(15'h0573, 8'h01);
        send(2, 64'hABCD_0000_1234_0000);
        for (int i = 0; i < 2; i++) take({3'b000, 64'hABCD_0000_1234_0000 + 64'(i)}, ALL);
        wr(15'h0571, 8'h00);
        wr(15'h0573, 8'h00);
        stall = 1'b1;
        send(2, 64'h5);
        wr(15'h0000, 8'h81);
        rd(15'h0000, 8'h00);
        stall = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk(67'(i_lane.words.size()), 67'h0, ALL);
    endtask : t_sample

    task automatic t_fifo();
        int n;
        n = 0;
        stall = 1'b1;
        repeat (20) begin
            @(negedge clk_sys);
            adc_valid = 1'b1;
            adc_data = 64'h0F00 + 64'(n);
            if (adc_ready) n++;
        end
        @(negedge clk_sys);
        adc_valid = 1'b0;
        chk(67'(n >= 4 && n < 20), 67'h1, ALL);
        stall = 1'b0;
        slow = 1'b1;
        for (int i = 0; i < n; i++) take({3'b000, 64'h0F00 + 64'(i)}, ALL);
        slow = 1'b0;
    endtask : t_fifo

    initial begin
        repeat (40000) @(posedge clk_sys);
        bad_count++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        t_regs_raw();
        t_words();
        t_prbs();
        t_user();
        t_leave();
        t_sample();
        t_fifo();
        summarize();
    end
endmodule : tb_top

bind stp_pattern_gen stp_pattern_gen_checker #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_point(out_point), .out_is_pattern(out_is_pattern));
